// ### design/tdm_port_pkg.sv
// shared constants for the tdm codec frame port, both ends
// assumes a single system clock; bit clock derived or sampled from it
package tdm_port_pkg;
    localparam int WORD_W = 16;
    localparam int SLOT_BITS = 16;
    localparam int FRAME_SLOTS = 16;
    localparam int FRAME_BITS = 256;
    localparam int POS_W = 8;
    localparam logic [3:0] CTRL_SLOT_CMD = 4'h0;
    localparam logic [3:0] CTRL_SLOT_DATA = 4'h1;
    localparam logic [3:0] DATA_SLOT_FIRST = 4'h2;
    localparam logic [3:0] DATA_SLOT_LAST = 4'h9;
    localparam int DATA_SLOTS = 8;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [POS_W-1:0] POS_RESET = 8'hFF;
    localparam int RW_BIT = 15;
    localparam int DEV_HI_BIT = 14;
    localparam int DEV_LO_BIT = 13;
    localparam int REG_MSB = 12;
    localparam int REG_LSB = 5;
    localparam int CDATA_MSB = 15;
    localparam int CDATA_LSB = 8;
    localparam logic [7:0] REG_NONE = 8'h00;
    localparam int BCLK_HALF = 8;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [1:0] {
        ST_HUNT = 2'b01,
        ST_LOCK = 2'b10
    } link_state_e;
endpackage

// ### design/tdm_link_if.sv
// four-wire tdm link between codec end and processor end
// bit clock and frame strobe are two-way; enables low while driving
`timescale 1ns/1ps
interface tdm_link_if;
    logic bclk_dev;
    logic bclk_dev_oe_n;
    logic fs_dev;
    logic fs_dev_oe_n;
    logic bclk_host;
    logic bclk_host_oe_n;
    logic fs_host;
    logic fs_host_oe_n;
    logic sdout;
    logic sdin;
    logic bclk;
    logic frame_strobe;
    assign bclk = !bclk_dev_oe_n ? bclk_dev :
                  (!bclk_host_oe_n ? bclk_host : 1'b0);
    assign frame_strobe = !fs_dev_oe_n ? fs_dev :
                          (!fs_host_oe_n ? fs_host : 1'b0);
    modport dev_end(output bclk_dev, output bclk_dev_oe_n,
                    output fs_dev, output fs_dev_oe_n, output sdout,
                    input bclk, input frame_strobe, input sdin);
    modport host_end(output bclk_host, output bclk_host_oe_n,
                     output fs_host, output fs_host_oe_n, output sdin,
                     input bclk, input frame_strobe, input sdout);
endinterface

// ### design/codec_tdm_port.sv
// codec end of the tdm frame port, with its sample fifo
// assumes the processor end sits on the tdm_link_if carrier
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule // sample_fifo

module codec_tdm_port
    import tdm_port_pkg::*;
#(
    parameter int HALF_DIV = BCLK_HALF,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic MASTER_MODE,
    input wire logic CTRL_SEL_N,
    input wire logic DEVICE_ADDR_BIT_HIGH,
    input wire logic DEVICE_ADDR_BIT_LOW,
    input wire logic ADC_VALID,
    output logic ADC_READY,
    input wire logic [WORD_W-1:0] ADC_DATA,
    output logic DAC_VALID,
    output logic [WORD_W-1:0] DAC_DATA,
    output logic [2:0] DAC_CHAN,
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    tdm_link_if.dev_end link
);
    import tdm_port_pkg::*;
    localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [DW-1:0] DIV_END = DW'(HALF_DIV - 1);

    logic [6:0] meta_q;
    logic [6:0] sync_q;
    logic [DW-1:0] div_q;
    logic bclk_q;
    logic bclk_d1_q;
    logic fs_q;
    logic [POS_W-1:0] pos_q;
    logic [WORD_W-1:0] rx_q;
    logic [WORD_W-1:0] tx_q;
    logic [WORD_W-1:0] cmd_q;
    logic rd_pend_q;
    link_state_e state_q;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;

    // pins from outside pass two flops first
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {MASTER_MODE, CTRL_SEL_N, DEVICE_ADDR_BIT_HIGH,
                       DEVICE_ADDR_BIT_LOW, link.bclk, link.frame_strobe,
                       link.sdin};
            sync_q <= meta_q;
        end
    end
    wire master = sync_q[6];
    wire ctrl_ok = !sync_q[5];
    wire [1:0] my_addr = sync_q[4:3];
    wire bclk_in = sync_q[2];
    wire fs_in = sync_q[1];
    wire din_in = sync_q[0];

    // bit clock generator and edge events
    wire gen_tick = master && (div_q == DIV_END);
    wire ext_rise = !master && bclk_in && !bclk_d1_q;
    wire ext_fall = !master && !bclk_in && bclk_d1_q;
    wire rise = (gen_tick && !bclk_q) || ext_rise;
    wire fall = (gen_tick && bclk_q) || ext_fall;
    wire strobe_seen = master ? fs_q : fs_in;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_q <= '0;
            bclk_q <= 1'b0;
            bclk_d1_q <= 1'b0;
        end else begin
            bclk_d1_q <= bclk_in;
            if (!master || gen_tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + DW'(1);
            end
            if (gen_tick) begin
                bclk_q <= !bclk_q;
            end
        end
    end

    // receive side: position of the bit sampled now
    wire [POS_W-1:0] cur_pos = strobe_seen ? '0 : pos_q + POS_W'(1);
    wire [3:0] cur_slot = cur_pos[7:4];
    wire [WORD_W-1:0] rx_word = {rx_q[WORD_W-2:0], din_in};
    wire word_done = fall && (state_q == ST_LOCK || strobe_seen) &&
                     (cur_pos[3:0] == BIT_LAST);
    wire cmd_hit = ctrl_ok && (rx_word[DEV_HI_BIT:DEV_LO_BIT] == my_addr);
    wire data_rx = (cur_slot >= DATA_SLOT_FIRST) &&
                   (cur_slot <= DATA_SLOT_LAST);
    wire cmd_done = word_done && (cur_slot == CTRL_SLOT_CMD);
    wire wdat_done = word_done && (cur_slot == CTRL_SLOT_DATA);
    wire wr_hit = ctrl_ok && cmd_q[RW_BIT] &&
                  (cmd_q[DEV_HI_BIT:DEV_LO_BIT] == my_addr) &&
                  (cmd_q[REG_MSB:REG_LSB] != REG_NONE);

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pos_q <= POS_RESET;
            rx_q <= '0;
            state_q <= ST_HUNT;
        end else if (fall) begin
            pos_q <= cur_pos;
            rx_q <= rx_word;
            if (strobe_seen) begin
                state_q <= ST_LOCK;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_q <= '0;
            rd_pend_q <= 1'b0;
            REG_RD <= 1'b0;
            REG_WR <= 1'b0;
            REG_ADDR <= '0;
            REG_WDATA <= '0;
            DAC_VALID <= 1'b0;
            DAC_DATA <= '0;
            DAC_CHAN <= '0;
        end else begin
            REG_RD <= 1'b0;
            REG_WR <= 1'b0;
            DAC_VALID <= 1'b0;
            if (cmd_done) begin
                cmd_q <= rx_word;
                rd_pend_q <= cmd_hit && !rx_word[RW_BIT];
                REG_RD <= cmd_hit && !rx_word[RW_BIT];
                if (cmd_hit) begin
                    REG_ADDR <= rx_word[REG_MSB:REG_LSB];
                end
            end
            if (wdat_done) begin
                rd_pend_q <= 1'b0;
                if (wr_hit) begin
                    REG_WR <= 1'b1;
                    REG_WDATA <= rx_word[CDATA_MSB:CDATA_LSB];
                end
            end
            if (word_done && data_rx) begin
                DAC_VALID <= 1'b1;
                DAC_DATA <= rx_word;
                DAC_CHAN <= 3'(cur_slot - DATA_SLOT_FIRST);
            end
        end
    end

    // transmit side: position of the bit launched now
    wire [POS_W-1:0] nxt_pos = pos_q + POS_W'(1);
    wire [3:0] nxt_slot = nxt_pos[7:4];
    wire load = rise && (nxt_pos[3:0] == BIT_FIRST);
    wire data_tx = (nxt_slot >= DATA_SLOT_FIRST) &&
                   (nxt_slot <= DATA_SLOT_LAST);
    wire pop = load && data_tx && (state_q == ST_LOCK) && fifo_valid;
    wire rdback = (nxt_slot == CTRL_SLOT_DATA) && rd_pend_q;
    wire [WORD_W-1:0] tx_word = pop ? fifo_data :
                                (rdback ? {REG_RDATA, 8'h00} : '0);

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tx_q <= '0;
            fs_q <= 1'b0;
        end else if (rise) begin
            fs_q <= master && (nxt_pos == '0);
            if (load) begin
                tx_q <= tx_word;
            end else begin
                tx_q <= {tx_q[WORD_W-2:0], 1'b0};
            end
        end
    end

    sample_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_sample_fifo (
        .clk(MCLK),
        .rst(SYS_RST),
        .in_valid(ADC_VALID),
        .in_ready(ADC_READY),
        .in_data(ADC_DATA),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // link drive; enables low while this end drives
    assign link.bclk_dev = bclk_q;
    assign link.bclk_dev_oe_n = !master;
    assign link.fs_dev = fs_q;
    assign link.fs_dev_oe_n = !master;
    assign link.sdout = tx_q[WORD_W-1];
endmodule // codec_tdm_port

// ### design/tdm_host_port.sv
// processor end of the tdm frame port
// assumes the codec end sits on the tdm_link_if carrier
`timescale 1ns/1ps
module tdm_host_port
    import tdm_port_pkg::*;
#(
    parameter int HALF_DIV = BCLK_HALF
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic MASTER_MODE,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic CMD_WRITE,
    input wire logic [1:0] CMD_DEV_ADDR,
    input wire logic [7:0] CMD_REG,
    input wire logic [7:0] CMD_WDATA,
    output logic RD_VALID,
    output logic [7:0] RD_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic [WORD_W-1:0] TX_DATA,
    output logic RX_VALID,
    output logic [WORD_W-1:0] RX_DATA,
    output logic [2:0] RX_CHAN,
    tdm_link_if.host_end link
);
    import tdm_port_pkg::*;
    localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [DW-1:0] DIV_END = DW'(HALF_DIV - 1);

    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [DW-1:0] div_q;
    logic bclk_q;
    logic bclk_d1_q;
    logic fs_q;
    logic [POS_W-1:0] pos_q;
    logic [WORD_W-1:0] rx_q;
    logic [WORD_W-1:0] tx_q;
    logic wr_q;
    logic rd_wait_q;
    logic [7:0] wdata_q;
    link_state_e state_q;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {MASTER_MODE, link.bclk, link.frame_strobe,
                       link.sdout};
            sync_q <= meta_q;
        end
    end
    wire master = sync_q[3];
    wire bclk_in = sync_q[2];
    wire fs_in = sync_q[1];
    wire dout_in = sync_q[0];

    wire gen_tick = master && (div_q == DIV_END);
    wire rise = (gen_tick && !bclk_q) ||
                (!master && bclk_in && !bclk_d1_q);
    wire fall = (gen_tick && bclk_q) ||
                (!master && !bclk_in && bclk_d1_q);
    wire strobe_seen = master ? fs_q : fs_in;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_q <= '0;
            bclk_q <= 1'b0;
            bclk_d1_q <= 1'b0;
        end else begin
            bclk_d1_q <= bclk_in;
            if (!master || gen_tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + DW'(1);
            end
            if (gen_tick) begin
                bclk_q <= !bclk_q;
            end
        end
    end

    wire [POS_W-1:0] cur_pos = strobe_seen ? '0 : pos_q + POS_W'(1);
    wire [3:0] cur_slot = cur_pos[7:4];
    wire [WORD_W-1:0] rx_word = {rx_q[WORD_W-2:0], dout_in};
    wire word_done = fall && (state_q == ST_LOCK || strobe_seen) &&
                     (cur_pos[3:0] == BIT_LAST);
    wire data_rx = (cur_slot >= DATA_SLOT_FIRST) &&
                   (cur_slot <= DATA_SLOT_LAST);

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pos_q <= POS_RESET;
            rx_q <= '0;
            state_q <= ST_HUNT;
        end else if (fall) begin
            pos_q <= cur_pos;
            rx_q <= rx_word;
            if (strobe_seen) begin
                state_q <= ST_LOCK;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RD_VALID <= 1'b0;
            RD_DATA <= '0;
            RX_VALID <= 1'b0;
            RX_DATA <= '0;
            RX_CHAN <= '0;
        end else begin
            RD_VALID <= word_done && (cur_slot == CTRL_SLOT_DATA) &&
                        rd_wait_q;
            RX_VALID <= word_done && data_rx;
            if (word_done && (cur_slot == CTRL_SLOT_DATA)) begin
                RD_DATA <= rx_word[CDATA_MSB:CDATA_LSB];
            end
            if (word_done && data_rx) begin
                RX_DATA <= rx_word;
                RX_CHAN <= 3'(cur_slot - DATA_SLOT_FIRST);
            end
        end
    end

    wire [POS_W-1:0] nxt_pos = pos_q + POS_W'(1);
    wire [3:0] nxt_slot = nxt_pos[7:4];
    wire load = rise && (nxt_pos[3:0] == BIT_FIRST) &&
                (state_q == ST_LOCK);
    wire data_tx = (nxt_slot >= DATA_SLOT_FIRST) &&
                   (nxt_slot <= DATA_SLOT_LAST);
    wire cmd_take = load && (nxt_slot == CTRL_SLOT_CMD) && CMD_VALID;
    wire [WORD_W-1:0] cmd_word = {CMD_WRITE, CMD_DEV_ADDR, CMD_REG,
                                  5'h00};
    assign CMD_READY = load && (nxt_slot == CTRL_SLOT_CMD);
    assign TX_READY = load && data_tx;
    wire [WORD_W-1:0] tx_word =
        cmd_take ? cmd_word :
        ((nxt_slot == CTRL_SLOT_DATA) && wr_q) ? {wdata_q, 8'h00} :
        (data_tx && TX_VALID) ? TX_DATA : '0;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tx_q <= '0;
            fs_q <= 1'b0;
            wr_q <= 1'b0;
            rd_wait_q <= 1'b0;
            wdata_q <= '0;
        end else begin
            if (rise) begin
                fs_q <= master && (nxt_pos == '0);
                if (load) begin
                    tx_q <= tx_word;
                end else begin
                    tx_q <= {tx_q[WORD_W-2:0], 1'b0};
                end
            end
            if (load && (nxt_slot == CTRL_SLOT_CMD)) begin
                wr_q <= cmd_take && CMD_WRITE;
                rd_wait_q <= cmd_take && !CMD_WRITE;
                wdata_q <= CMD_WDATA;
            end
        end
    end

    assign link.bclk_host = bclk_q;
    assign link.bclk_host_oe_n = !master;
    assign link.fs_host = fs_q;
    assign link.fs_host_oe_n = !master;
    assign link.sdin = tx_q[WORD_W-1];
endmodule // tdm_host_port

// ### verification/tdm_link_properties.sv
// link checker for the tdm frame port, watching the carrier's signals
// assumes the bench places it beside the tdm_link_if instance
`timescale 1ns/1ps
module tdm_link_properties #(
    parameter int HALF_DIV = 8
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic bclk,
    input wire logic frame_strobe,
    input wire logic bclk_dev_oe_n,
    input wire logic fs_dev_oe_n,
    input wire logic bclk_host_oe_n,
    input wire logic fs_host_oe_n,
    input wire logic sdout,
    input wire logic sdin
);
    logic bclk_q, fs_q, have_q;
    logic [8:0] rise_q;
    logic [8:0] rise_d;
    logic [7:0] half_q;
    logic [7:0] half_d;
    wire bclk_rise = bclk && !bclk_q;
    wire fs_rise = frame_strobe && !fs_q;
    wire cmd_pad = rise_q >= 9'h00C && rise_q <= 9'h010;
    wire data_pad = rise_q >= 9'h019 && rise_q <= 9'h020;
    assign rise_d = fs_rise ? {8'h00, bclk_rise} : rise_q + {8'h00, bclk_rise};
    assign half_d = (bclk != bclk_q) ? 8'h00 : half_q + 8'h01;
    // rises since strobe, cycles since last bit-clock edge
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bclk_q <= 1'b0;
            fs_q <= 1'b0;
            have_q <= 1'b0;
            rise_q <= 9'h000;
            half_q <= 8'h00;
        end else begin
            bclk_q <= bclk;
            fs_q <= frame_strobe;
            have_q <= have_q || fs_rise;
            rise_q <= rise_d;
            half_q <= half_d;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    property p_frame_len;
        fs_rise && have_q |-> rise_q == 9'h100;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame is not 256 bit clocks");
    property p_fs_width;
        $fell(frame_strobe) |-> bclk_rise && rise_q == 9'h001;
    endproperty
    a_fs_width: assert property (p_fs_width)
        else $error("frame strobe not one bit period");
    property p_half_period;
        (bclk != bclk_q) && have_q |-> half_q == 8'(HALF_DIV - 1);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("bit clock half period wrong");
    property p_one_driver;
        !(!bclk_dev_oe_n && !bclk_host_oe_n);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the bit clock");
    property p_drive_pair;
        bclk_dev_oe_n == fs_dev_oe_n && bclk_host_oe_n == fs_host_oe_n;
    endproperty
    a_drive_pair: assert property (p_drive_pair)
        else $error("clock and strobe driven by different ends");
    property p_sdout_launch;
        $changed(sdout) && have_q |-> bclk;
    endproperty
    a_sdout_launch: assert property (p_sdout_launch)
        else $error("device output changed while bit clock low");
    property p_sdin_launch;
        $changed(sdin) && have_q |-> bclk;
    endproperty
    a_sdin_launch: assert property (p_sdin_launch)
        else $error("device input changed while bit clock low");
    property p_idle_slots;
        $fell(bclk) && have_q && rise_q > 9'h0A0 |-> !sdout && !sdin;
    endproperty
    a_idle_slots: assert property (p_idle_slots)
        else $error("unused slot not zero");
    property p_cmd_pad;
        $fell(bclk) && have_q && cmd_pad |-> !sdin;
    endproperty
    a_cmd_pad: assert property (p_cmd_pad)
        else $error("command word low bits not zero");
    property p_data_pad;
        $fell(bclk) && have_q && data_pad |-> !sdin && !sdout;
    endproperty
    a_data_pad: assert property (p_data_pad)
        else $error("control data low byte not zero");
    c_dev_master: cover property (fs_rise && have_q && !fs_dev_oe_n);
    c_host_master: cover property (fs_rise && have_q && !fs_host_oe_n);
    c_read_bit: cover property ($fell(bclk) && rise_q == 9'h011 && sdout);
endmodule // tdm_link_properties

// ### verification/codec_tdm_serial_frame_port_bench.sv
// bench: codec end and processor end joined on one carrier
// assumes the tdm_port_pkg constants and a 100 MHz system clock
`timescale 1ns/1ps
module codec_tdm_serial_frame_port_bench;
    import tdm_port_pkg::*;
    localparam int HD = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic dev_master = 1'b1;
    logic sel_n = 1'b0;
    logic [1:0] dev_addr = 2'h1;
    logic adc_valid = 1'b0;
    logic [WORD_W-1:0] adc_data = 16'h0000;
    logic [7:0] reg_rdata = 8'h00;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [1:0] cmd_dev = 2'h0;
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic tx_valid = 1'b0;
    logic tx_on = 1'b0;
    logic tx_pend = 1'b0;
    logic [WORD_W-1:0] tx_data = 16'h0001;
    logic frame_seen = 1'b0;
    logic [15:0] s0_sh = 16'h0000;
    logic [4:0] s0_pos = 5'h00;
    wire adc_ready, dac_valid, reg_wr, reg_rd, cmd_ready, rd_valid;
    wire tx_ready, rx_valid;
    wire [WORD_W-1:0] dac_data, rx_data;
    wire [2:0] dac_chan, rx_chan;
    wire [7:0] reg_addr, reg_wdata, rd_data;
    wire [18:0] reg_seen = {2'h0, reg_wr, reg_addr,
                            reg_wr ? reg_wdata : 8'h00};
    logic [18:0] rx_q[$], dac_q[$], reg_q[$], rd_q[$], s0_q[$];
    int fails = 0;
    int n_compared = 0;
    int tx_idx = 0;
    tdm_link_if link();
    codec_tdm_port #(.HALF_DIV(HD), .DEPTH(FIFO_DEPTH)) u_codec_tdm_port (
        .MCLK(mclk), .SYS_RST(rst), .MASTER_MODE(dev_master),
        .CTRL_SEL_N(sel_n), .DEVICE_ADDR_BIT_HIGH(dev_addr[1]),
        .DEVICE_ADDR_BIT_LOW(dev_addr[0]), .ADC_VALID(adc_valid),
        .ADC_READY(adc_ready), .ADC_DATA(adc_data), .DAC_VALID(dac_valid),
        .DAC_DATA(dac_data), .DAC_CHAN(dac_chan), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .link(link));
    tdm_host_port #(.HALF_DIV(HD)) u_tdm_host_port (
        .MCLK(mclk), .SYS_RST(rst), .MASTER_MODE(!dev_master),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
        .CMD_DEV_ADDR(cmd_dev), .CMD_REG(cmd_reg), .CMD_WDATA(cmd_wdata),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_DATA(tx_data), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_CHAN(rx_chan), .link(link));
    tdm_link_properties #(.HALF_DIV(HD)) u_tdm_link_properties (
        .MCLK(mclk), .SYS_RST(rst), .bclk(link.bclk),
        .frame_strobe(link.frame_strobe),
        .bclk_dev_oe_n(link.bclk_dev_oe_n), .fs_dev_oe_n(link.fs_dev_oe_n),
        .bclk_host_oe_n(link.bclk_host_oe_n),
        .fs_host_oe_n(link.fs_host_oe_n), .sdout(link.sdout),
        .sdin(link.sdin));
    initial begin
        forever #5 mclk = ~mclk;
    end
    function automatic logic [15:0] rnd16();
        // nonzero, since zero words mark empty slots; every bit random
        return 16'($urandom_range(16'hFFFF, 16'h0001));
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic take(ref logic [18:0] q[$], input string what,
                        input logic [18:0] seen);
        check(what, seen, q.size() > 0 ? q.pop_front() : ~seen);
    endtask
    // result watcher, plus the processor-side sample stream
    always @(negedge mclk) begin
        reg_rdata <= ~reg_addr;
        if (!rst && rx_valid && rx_data !== 16'h0000)
            take(rx_q, "rx word", {rx_chan, rx_data});
        if (!rst && dac_valid && dac_data !== 16'h0000)
            take(dac_q, "dac word", {dac_chan, dac_data});
        if (!rst && (reg_wr || reg_rd))
            take(reg_q, "reg access", reg_seen);
        if (!rst && rd_valid)
            take(rd_q, "read byte", {11'h000, rd_data});
        if (tx_pend) begin
            tx_pend = 1'b0;
            tx_data = rnd16();
            tx_valid = tx_on;
        end else if (!rst && frame_seen && tx_valid && tx_ready) begin
            dac_q.push_back({3'(tx_idx % 8), tx_data});
            tx_idx++;
            tx_pend = 1'b1;
        end
    end
    always @(posedge link.frame_strobe) begin
        frame_seen <= 1'b1;
    end
    // slot 0 as seen on the wire, bit 15 first
    always @(negedge link.bclk) begin
        s0_sh = {s0_sh[14:0], link.sdin};
        s0_pos = link.frame_strobe ? 5'h00 : s0_pos + 5'h01;
        if (s0_pos == 5'h0F && s0_q.size() > 0)
            check("slot0 word", {3'h0, s0_sh}, s0_q.pop_front());
    end
    task automatic send_cmd(input logic wr, input logic [1:0] dv,
                            input logic [7:0] rg, input logic sn);
        int t;
        sel_n = sn;
        cmd_write = wr;
        cmd_dev = dv;
        cmd_reg = rg;
        cmd_wdata = 8'($urandom);
        cmd_valid = 1'b1;
        for (t = 0; t < 6000 && cmd_ready !== 1'b1; t++) @(negedge mclk);
        if (t == 6000) begin
            fails++;
            stop_test();
        end
        @(posedge mclk);
        s0_q.push_back({3'h0, wr, dv, rg, 5'h00});
        if (!sn && dv == dev_addr && (!wr || rg != 8'h00))
            reg_q.push_back({2'h0, wr, rg, wr ? cmd_wdata : 8'h00});
        if (!wr)
            rd_q.push_back({11'h000, (!sn && dv == dev_addr) ? ~rg : 8'h00});
        @(negedge mclk);
        cmd_valid = 1'b0;
        // let both control slots finish before the select pin moves
        repeat (40 * 2 * HD) @(negedge mclk);
    endtask
    task automatic run_mode(input logic master);
        int i;
        int t;
        rst = 1'b1;
        dev_master = master;
        tx_on = 1'b0;
        tx_valid = 1'b0;
        sel_n = 1'b0;
        rx_q.delete();
        dac_q.delete();
        reg_q.delete();
        rd_q.delete();
        s0_q.delete();
        frame_seen = 1'b0;
        tx_idx = 0;
        dev_addr = 2'($urandom_range(3, 1));
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < FIFO_DEPTH; i++) begin
            adc_valid = 1'b1;
            adc_data = rnd16();
            check("adc ready", adc_ready, 1'b1);
            rx_q.push_back({3'(i % 8), adc_data});
            @(negedge mclk);
        end
        adc_valid = 1'b0;
        check("adc full", adc_ready, 1'b0);
        tx_data = rnd16();
        tx_valid = 1'b1;
        tx_on = 1'b1;
        for (i = 0; i < 4; i++)
            send_cmd(i[0], 2'(i), 8'($urandom_range(255, 1)), 1'b0);
        send_cmd(1'b1, dev_addr, 8'h00, 1'b0);
        send_cmd(1'b1, dev_addr, 8'h3C, 1'b1);
        send_cmd(1'b0, dev_addr, 8'h5A, 1'b1);
        tx_on = 1'b0;
        for (t = 0; t < 20000 && (tx_valid || dac_q.size() > 0 ||
             rx_q.size() > 0); t++) @(negedge mclk);
        if (t == 20000) begin
            fails++;
            stop_test();
        end
        check("leftover", reg_q.size() + rd_q.size() + s0_q.size(), 0);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(94542));
        run_mode(1'b1);
        run_mode(1'b0);
        stop_test();
    end
endmodule // codec_tdm_serial_frame_port_bench
